// File: pkg/fei_pkg.sv
// shared types and constants for the fpu error reporting handshake
package fei_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // cycle counts at 10 MHz
    localparam int PULSE_CYCLES  = 2;
    localparam int WINDOW_CYCLES = 4;
    localparam int EXEC_CYCLES   = 3;
    localparam int CNT_W         = 4;

    // reset values
    localparam logic RST_ERR_OUT_N = 1'b1;
    localparam logic RST_SYNC_N    = 1'b1;
    localparam logic RST_SYNC      = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        KIND_WAITING,
        KIND_NOWAIT,
        KIND_WAIT,
        KIND_VECTOR
    } fei_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PULSE,
        ST_WINDOW,
        ST_SERVICE,
        ST_EXEC,
        ST_FROZEN
    } fei_state_t;

    typedef struct packed {
        logic      valid;
        fei_kind_t kind;
    } fei_instr_t;

    typedef struct packed {
        logic valid;
        logic unmasked;
        logic immediate;
        logic vector;
    } fei_exc_t;

endpackage : fei_pkg

// File: core/fei_core.sv
// fpu error output, ignore input, interrupt window and freeze sequencing
`timescale 1ns/1ps

module fei_core #(
    parameter int PULSE_LEN  = fei_pkg::PULSE_CYCLES,
    parameter int WINDOW_LEN = fei_pkg::WINDOW_CYCLES,
    parameter int EXEC_LEN   = fei_pkg::EXEC_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               clkEn,
    input  wire fei_pkg::fei_instr_t instr,
    input  wire fei_pkg::fei_exc_t  fpuEvent,
    input  wire logic               errClear,
    input  wire logic               native_error_report_bit,
    input  wire logic               laterGen,
    input  wire logic               ifFlag,
    input  wire logic               svcDone,
    input  wire logic               ignore_numeric_error_in_n,
    input  wire logic               maskable_irq_in,
    output logic                    fpu_error_out_n,
    output logic                    frozen,
    output logic                    busy,
    output logic                    irqTake,
    output logic                    nativeFault
);
    import fei_pkg::*;

    // refused at elaboration: the phase counters cannot reach these lengths
    if (PULSE_LEN < 1 || WINDOW_LEN < 1 || EXEC_LEN < 1 ||
        PULSE_LEN >= (1 << CNT_W) || WINDOW_LEN >= (1 << CNT_W) || EXEC_LEN >= (1 << CNT_W)) begin : g_bad_len
        $error("fei_core: phase lengths must lie in 1 .. 2**CNT_W-1");
    end

    localparam logic [CNT_W-1:0] PULSE_LAST  = CNT_W'(PULSE_LEN - 1);
    localparam logic [CNT_W-1:0] WINDOW_LAST = CNT_W'(WINDOW_LEN - 1);
    localparam logic [CNT_W-1:0] EXEC_LAST   = CNT_W'(EXEC_LEN - 1);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic ignS1_n;
    logic ignS2_n;
    logic irqS1;
    logic irqS2;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ignS1_n <= RST_SYNC_N;
            ignS2_n <= RST_SYNC_N;
            irqS1   <= RST_SYNC;
            irqS2   <= RST_SYNC;
        end else if (clkEn) begin
            ignS1_n <= ignore_numeric_error_in_n;
            ignS2_n <= ignS1_n;
            irqS1   <= maskable_irq_in;
            irqS2   <= irqS1;
        end
    end

    logic compat;
    logic ignActive;
    logic irqReq;

    assign compat    = ~native_error_report_bit;
    assign ignActive = compat & ~ignS2_n;
    assign irqReq    = irqS2 & ifFlag;

    ////////////////////////////////////////////////////////////////////////////
    // error tracking
    logic errPending;
    logic errImm;
    logic errAsserted;
    logic newErr;

    assign newErr = fpuEvent.valid & fpuEvent.unmasked & ~fpuEvent.vector;

    // a new error in the clearing cycle survives the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            errPending <= 1'b0;
            errImm     <= 1'b0;
        end else if (clkEn) begin
            if (newErr) begin
                errPending <= 1'b1;
                errImm     <= fpuEvent.immediate | laterGen;
            end else if (errClear) begin
                errPending <= 1'b0;
                errImm     <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    fei_state_t       state;
    fei_state_t       retState;
    fei_state_t       next_state;
    logic [CNT_W-1:0] cnt;
    logic             accept;
    logic             freezeHit;
    logic             pulseHit;

    assign accept    = instr.valid & (state == ST_IDLE);
    assign freezeHit = errPending & ~ignActive;
    assign pulseHit  = errPending & compat & ~ignActive & ~errAsserted & ~laterGen;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (instr.valid) begin
                    case (instr.kind)
                        KIND_VECTOR: next_state = ST_EXEC;
                        KIND_NOWAIT: begin
                            if (pulseHit) begin
                                next_state = ST_PULSE;
                            end else if (laterGen) begin
                                next_state = ST_EXEC;
                            end else begin
                                next_state = ST_WINDOW;
                            end
                        end
                        default: begin
                            if (freezeHit && compat) begin
                                next_state = ST_FROZEN;
                            end else if (freezeHit) begin
                                next_state = ST_IDLE;
                            end else if (instr.kind == KIND_WAITING) begin
                                next_state = ST_WINDOW;
                            end else begin
                                next_state = ST_EXEC;
                            end
                        end
                    endcase
                end else if (irqReq) begin
                    next_state = ST_SERVICE;
                end
            end
            ST_PULSE: begin
                if (cnt == PULSE_LAST) begin
                    next_state = ST_WINDOW;
                end
            end
            ST_WINDOW: begin
                if (irqReq) begin
                    next_state = ST_SERVICE;
                end else if (cnt == WINDOW_LAST) begin
                    next_state = ST_EXEC;
                end
            end
            ST_SERVICE: begin
                if (svcDone) begin
                    next_state = retState;
                end
            end
            ST_EXEC: begin
                if (cnt == EXEC_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FROZEN: begin
                if (!freezeHit) begin
                    next_state = ST_EXEC;
                end else if (irqReq) begin
                    next_state = ST_SERVICE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state    <= ST_IDLE;
            retState <= ST_IDLE;
            cnt      <= '0;
        end else if (clkEn) begin
            state <= next_state;
            if (next_state != state) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + CNT_W'(1);
            end
            if (next_state == ST_SERVICE && state != ST_SERVICE) begin
                // window interrupts resume the instruction, freezes recheck
                retState <= (state == ST_WINDOW) ? ST_EXEC : (state == ST_FROZEN) ? ST_FROZEN : ST_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error output latch: held until the handler clears the error
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            errAsserted <= 1'b0;
        end else if (clkEn) begin
            if (compat && !ignActive && ((newErr && (fpuEvent.immediate || laterGen)) ||
                                         (errPending && errImm))) begin
                errAsserted <= 1'b1;
            end else if (compat && next_state == ST_FROZEN) begin
                errAsserted <= 1'b1;
            end else if (errClear || !errPending) begin
                errAsserted <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs: error output and frozen one cycle behind the state, busy and irqTake decoded from next_state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fpu_error_out_n <= RST_ERR_OUT_N;
            frozen          <= 1'b0;
            busy            <= 1'b0;
            irqTake         <= 1'b0;
            nativeFault     <= 1'b0;
        end else if (clkEn) begin
            fpu_error_out_n <= ~(compat & (errAsserted | (state == ST_PULSE)));
            frozen          <= (state == ST_FROZEN);
            busy            <= (next_state != ST_IDLE);
            irqTake         <= (next_state == ST_SERVICE) & (state != ST_SERVICE);
            nativeFault     <= accept & (instr.kind == KIND_WAITING || instr.kind == KIND_WAIT) &
                               freezeHit & ~compat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_pulse;
        (state == ST_PULSE)[*2];
    endsequence

    sequence s_window_after;
        clkEn && state == ST_WINDOW;
    endsequence

    property p_pulse_then_window;
        clkEn && $rose(state == ST_PULSE) |-> ##1 (state == ST_PULSE || !clkEn) ##1 s_window_after or
                                             !clkEn ##1 1'b1;
    endproperty
    a_pulse_then_window: assert property (p_pulse_then_window) else $error("pulse not followed by window");

    property p_pulse_shows;
        clkEn && state == ST_PULSE && compat |=> !fpu_error_out_n;
    endproperty
    a_pulse_shows: assert property (p_pulse_shows) else $error("error output missing during pulse");

    property p_if_blocks;
        clkEn && !ifFlag && state != ST_SERVICE && !svcDone |=> !irqTake;
    endproperty
    a_if_blocks: assert property (p_if_blocks) else $error("interrupt taken with enable flag clear");

    property p_native_quiet;
        clkEn && native_error_report_bit |=> fpu_error_out_n;
    endproperty
    a_native_quiet: assert property (p_native_quiet) else $error("error output active in native mode");

    property p_vector_exec;
        clkEn && accept && instr.kind == KIND_VECTOR |=> state == ST_EXEC;
    endproperty
    a_vector_exec: assert property (p_vector_exec) else $error("vector instruction not executed");

    property p_no_repulse;
        clkEn && accept && instr.kind == KIND_NOWAIT && errAsserted |=> state != ST_PULSE;
    endproperty
    a_no_repulse: assert property (p_no_repulse) else $error("no-wait pulsed an asserted error");

    property p_freeze;
        clkEn && accept && instr.kind == KIND_WAITING && freezeHit && compat |=> ##1 frozen;
    endproperty
    a_freeze: assert property (p_freeze) else $error("pending error did not freeze");

    property p_late_nowindow;
        clkEn && accept && instr.kind == KIND_NOWAIT && laterGen |=> state != ST_WINDOW;
    endproperty
    a_late_nowindow: assert property (p_late_nowindow) else $error("later generation opened no-wait window");

    property p_ignore_holds;
        clkEn && ignActive && !errAsserted && state != ST_FROZEN |=> !errAsserted;
    endproperty
    a_ignore_holds: assert property (p_ignore_holds) else $error("error asserted while ignore active");

    property p_exec_no_irq;
        clkEn && state == ST_EXEC && next_state == ST_EXEC |=> !irqTake;
    endproperty
    a_exec_no_irq: assert property (p_exec_no_irq) else $error("interrupt taken outside window");

endmodule : fei_core

// File: verif/fei_latch_model.sv
// external error latch and interrupt controller model
`timescale 1ns/1ps

module fei_latch_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic errOutN,
    input  wire logic ackPort,
    output logic      ignoreN,
    output logic      irqLine
);
    logic reqLatch;
    logic ignoreSet;

    ////////////////////////////////////////////////////////////////////////////
    // sampled every edge so even a two-cycle pulse is caught
    always_ff @(posedge clk) begin
        if (sys_rst)
            reqLatch <= 1'b0;
        else if (ackPort)
            reqLatch <= 1'b0;
        else if (!errOutN)
            reqLatch <= 1'b1;
    end

    // inactive error output clears at once, so ack after clear never arms
    always_ff @(posedge clk or posedge errOutN) begin
        if (errOutN)
            ignoreSet <= 1'b0;
        else if (sys_rst)
            ignoreSet <= 1'b0;
        else if (ackPort)
            ignoreSet <= 1'b1;
    end

    assign ignoreN = ~ignoreSet;
    assign irqLine = reqLatch;
endmodule : fei_latch_model

// File: verif/fpu_error_interrupt_handshake_test.sv
// self-checking bench for the fpu error handshake core
`timescale 1ns/1ps

module fpu_error_interrupt_handshake_test;
    import fei_pkg::*;
    logic       clk = 0, sys_rst = 1, errClear = 0, nativeBit = 0, laterGen = 0;
    logic       ifFlag = 1, svcDone = 0, ackPort = 0, clkEn = 1;
    fei_instr_t instr = '0;
    fei_exc_t   fpuEvent = '0;
    logic       errN, frozen, busy, irqTake, nativeFault, ignoreN, irqLine;
    logic       sawLow, sawHigh, sawTake, sawFrozen, sawFault, low;
    int         errors = 0, totalChecks = 0, cycles = 0, hCnt = 0;

    fei_core dut_u (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .instr(instr), .fpuEvent(fpuEvent),
        .errClear(errClear), .native_error_report_bit(nativeBit), .laterGen(laterGen), .ifFlag(ifFlag),
        .svcDone(svcDone), .ignore_numeric_error_in_n(ignoreN), .maskable_irq_in(irqLine),
        .fpu_error_out_n(errN), .frozen(frozen), .busy(busy), .irqTake(irqTake), .nativeFault(nativeFault));
    fei_latch_model far_u (.clk(clk), .sys_rst(sys_rst), .errOutN(errN), .ackPort(ackPort),
        .ignoreN(ignoreN), .irqLine(irqLine));

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic expectLow(input logic nat, input logic vec);
        return !nat && !vec;
    endfunction : expectLow

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        totalChecks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask : check

    task automatic conclude();
        if (errors == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic pulseEvent(input logic imm, input logic vec);
        fpuEvent = '{1'b1, 1'b1, imm, vec};
        tick(1);
        fpuEvent = '0;
    endtask : pulseEvent

    task automatic clearErr();
        errClear = 1'b1;
        tick(1);
        errClear = 1'b0;
        tick(4);
    endtask : clearErr

    task automatic watch(input int n);
        low = 1'b0;
        repeat (n) begin
            tick(1);
            low |= (errN === 1'b0);
        end
    endtask : watch

    task automatic startInstr(input fei_kind_t k);
        int n;
        n = 0;
        instr = '{1'b1, k};
        while (busy !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check(busy, 1'b1, "instruction not taken");
        instr.valid = 1'b0;
    endtask : startInstr

    task automatic runInstr(input fei_kind_t k);
        int n;
        n = 0;
        {sawLow, sawHigh, sawTake, sawFrozen, sawFault} = '0;
        startInstr(k);
        while (busy === 1'b1 && n < 80) begin
            sawLow |= (errN === 1'b0);
            sawHigh |= (errN === 1'b1);
            sawTake |= (irqTake === 1'b1);
            sawFrozen |= (frozen === 1'b1);
            sawFault |= (nativeFault === 1'b1);
            tick(1);
            n++;
        end
        check(busy, 1'b0, "instruction never finished");
    endtask : runInstr

    ////////////////////////////////////////////////////////////////////////////
    // handler stand-in: acknowledge port access, then service done
    always @(negedge clk) begin
        if (irqTake === 1'b1)
            hCnt = 1;
        else if (hCnt > 0)
            hCnt++;
        ackPort = (hCnt == 2);
        svcDone = (hCnt == 3);
        if (hCnt == 3)
            hCnt = 0;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        void'($urandom(59));
        tick(8);
        sys_rst = 1'b0;
        check({errN, frozen, busy, irqTake, nativeFault}, 8'h10, "reset values");
        tick(2);
        repeat (16) begin
            runInstr(fei_kind_t'($urandom_range(0, 3)));
            check({sawLow, sawFrozen}, 8'h00, "idle instruction touched error");
            tick($urandom_range(1, 3));
        end
        for (int c = 0; c < 4; c++) begin
            nativeBit = c[1];
            pulseEvent(1'b1, c[0]);
            watch(4);
            check(low, expectLow(c[1], c[0]), "immediate report");
            if (c == 2) begin
                // native mode drops a waiting instruction that meets the pending error
                instr = '{1'b1, KIND_WAIT};
                tick(1);
                check({nativeFault, busy}, 8'h02, "native fault missing");
                instr.valid = 1'b0;
                tick(1);
                check({nativeFault, busy, errN}, 8'h01, "native fault not a pulse");
            end
            if (c == 0) begin
                tick(12);
                check(ignoreN, 1'b0, "ignore not armed");
                runInstr(KIND_WAITING);
                check(sawFrozen, 1'b0, "froze under ignore");
            end
            clearErr();
            check({errN, ignoreN}, 8'h03, "error and ignore after clear");
            tick(10);
        end
        nativeBit = 1'b0;
        ifFlag = 1'b0;
        pulseEvent(1'b0, 1'b0);
        watch(4);
        check(low, 1'b0, "deferred reported early");
        startInstr(KIND_WAITING);
        watch(12);
        check({frozen, errN, irqTake}, 8'h04, "freeze with flag clear");
        // a clear while the clock enable is low must be lost
        clkEn = 1'b0;
        clearErr();
        check({frozen, errN, busy}, 8'h05, "state moved with clock enable low");
        clkEn = 1'b1;
        clearErr();
        ifFlag = 1'b1;
        tick(20);
        check({busy, errN, ignoreN}, 8'h03, "release after clear");
        pulseEvent(1'b0, 1'b0);
        runInstr(KIND_NOWAIT);
        check({sawLow, sawTake}, 8'h03, "no-wait pulse and window");
        check(errN, 1'b1, "no-wait left error asserted");
        clearErr();
        tick(10);
        runInstr(KIND_NOWAIT);
        check(sawLow, 1'b0, "no-wait after clear");
        ifFlag = 1'b0;
        pulseEvent(1'b1, 1'b0);
        tick(4);
        runInstr(KIND_NOWAIT);
        check({sawLow, sawHigh}, 8'h02, "asserted error changed");
        clearErr();
        ifFlag = 1'b1;
        tick(20);
        laterGen = 1'b1;
        pulseEvent(1'b0, 1'b0);
        watch(4);
        check(low, 1'b1, "later generation deferred");
        // request is already pending; the no-wait must not take it inside
        runInstr(KIND_NOWAIT);
        check({sawTake, sawLow}, 8'h01, "later generation no-wait window");
        tick(1);
        check(irqTake, 1'b1, "boundary interrupt missing");
        clearErr();
        tick(20);
        conclude();
    end
endmodule : fpu_error_interrupt_handshake_test
